// *** cpu_swi_trap_rti_index_ops_test.sv ***
// Self-checking bench for the exception and index unit
`timescale 1ns/1ps
module cpu_swi_trap_rti_index_ops_test;
  logic               ref_clk, rst, cmd_valid, cmd_ready, irq_pending;
  logic               irq_take, trap_taken, mem_ack, trap_seen, clk_en;
  logic [7:0]         mem_rdata;
  logic [3:0]         stall;
  logic [15:0]        s;
  sxu_pkg::sxu_cmd_s  cmd;
  sxu_pkg::sxu_bus_s  mem;
  sxu_pkg::sxu_regs_s regs, pre;
  int                 miscompares, checks_done, takes;

  sxu_core sxu_core_inst (.ref_clk, .rst, .clk_en, .cmd_valid, .cmd, .cmd_ready, .irq_pending,
    .irq_take, .mem, .mem_rdata, .mem_ack, .regs, .trap_taken);
  sxu_mem_model sxu_mem_model_inst (.ref_clk, .mem, .stall, .mem_rdata, .mem_ack);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Request logic drops its line once the unit accepts it
  always @(negedge ref_clk) begin
    if (irq_take === 1'b1) begin
      takes++;
      irq_pending = 1'b0;
    end
    if (trap_taken === 1'b1) trap_seen = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic run(input sxu_pkg::sxu_op_e op, input sxu_pkg::sxu_reg_e sr, input sxu_pkg::sxu_reg_e dr,
                     input logic [15:0] v, input logic [7:0] opc = 8'h00, input logic p2 = 1'b0);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd = '{op, sr, dr, v, opc, p2};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    @(negedge ref_clk);
    // Long operations hold ready low until memory work ends
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 500, 1'b1);
  endtask

  task automatic ld(input sxu_pkg::sxu_reg_e d, input logic [15:0] v);
    run(sxu_pkg::SXU_OP_LOAD, d, d, v);
  endtask

  task automatic cp(input sxu_pkg::sxu_reg_e sr, input sxu_pkg::sxu_reg_e d);
    run(sxu_pkg::SXU_OP_COPY, sr, d, 16'h0000);
  endtask

  // Stacked frame: flags lowest, return address highest
  task automatic stk();
    logic [71:0] e;
    e = {pre.condition_flags_register, pre.b, pre.a, pre.x, pre.y, pre.pc};
    chk(regs.sp, s - 16'h0009);
    chk(regs.condition_flags_register[sxu_pkg::IMASK_BIT], 1'b1);
    for (int i = 0; i < 9; i++) begin
      chk(sxu_mem_model_inst.m[s - 16'h0009 + 16'(i)], e[71 - 8 * i -: 8]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    ld(sxu_pkg::SXU_R_X, 16'h1234);
    cp(sxu_pkg::SXU_R_X, sxu_pkg::SXU_R_A);
    ld(sxu_pkg::SXU_R_X, 16'h0081);
    cp(sxu_pkg::SXU_R_X, sxu_pkg::SXU_R_B);
    ld(sxu_pkg::SXU_R_X, 16'hFFF0);
    ld(sxu_pkg::SXU_R_Y, 16'h0100);
    ld(sxu_pkg::SXU_R_SP, 16'h2000);
    run(sxu_pkg::SXU_OP_ABX, sxu_pkg::SXU_R_B, sxu_pkg::SXU_R_X, 16'h0000);
    run(sxu_pkg::SXU_OP_ABY, sxu_pkg::SXU_R_B, sxu_pkg::SXU_R_Y, 16'h0000);
    chk(regs.a, 8'h34);
    chk(regs.b, 8'h81);
    chk(regs.x, 16'h0071);
    chk(regs.y, 16'h0181);
    cp(sxu_pkg::SXU_R_SP, sxu_pkg::SXU_R_X);
    cp(sxu_pkg::SXU_R_B, sxu_pkg::SXU_R_Y);
    chk(regs.x, 16'h2000);
    chk(regs.y, 16'h0081);
    run(sxu_pkg::SXU_OP_STORE, sxu_pkg::SXU_R_SP, sxu_pkg::SXU_R_SP, 16'h3000);
    chk({sxu_mem_model_inst.m[16'h3000], sxu_mem_model_inst.m[16'h3001]}, 16'h2000);
    $display("test regs done");
  endtask

  task automatic t_cmp();
    run(sxu_pkg::SXU_OP_CMP, sxu_pkg::SXU_R_X, sxu_pkg::SXU_R_X, 16'h2000);
    chk({regs.condition_flags_register[sxu_pkg::Z_BIT], regs.condition_flags_register[sxu_pkg::C_BIT], regs.x}, {2'b10, 16'h2000});
    run(sxu_pkg::SXU_OP_CMP, sxu_pkg::SXU_R_SP, sxu_pkg::SXU_R_SP, 16'h2001);
    chk({regs.condition_flags_register[3:0], regs.sp}, {4'b1001, 16'h2000});
    run(sxu_pkg::SXU_OP_CMP, sxu_pkg::SXU_R_Y, sxu_pkg::SXU_R_Y, 16'h0081);
    chk({regs.condition_flags_register[sxu_pkg::Z_BIT], regs.y}, {1'b1, 16'h0081});
    run(sxu_pkg::SXU_OP_LEA, sxu_pkg::SXU_R_Y, sxu_pkg::SXU_R_Y, 16'h4321);
    chk(regs.y, 16'h4321);
    run(sxu_pkg::SXU_OP_SWAP, sxu_pkg::SXU_R_D, sxu_pkg::SXU_R_X, 16'h0000);
    chk({regs.a, regs.b, regs.x}, 32'h2000_3481);
    // Frozen clock enable must drop the load
    clk_en = 1'b0;
    ld(sxu_pkg::SXU_R_X, 16'h5555);
    chk(regs.x, 16'h3481);
    clk_en = 1'b1;
    $display("test compare done");
  endtask

  task automatic t_trap();
    pre = regs;
    s = regs.sp;
    run(sxu_pkg::SXU_OP_DECODE, sxu_pkg::SXU_R_A, sxu_pkg::SXU_R_A, 16'h0000, 8'h35, 1'b1);
    run(sxu_pkg::SXU_OP_DECODE, sxu_pkg::SXU_R_A, sxu_pkg::SXU_R_A, 16'h0000, 8'hFF, 1'b0);
    chk({regs, trap_seen}, {pre, 1'b0});
    stall = 4'h1;
    run(sxu_pkg::SXU_OP_DECODE, sxu_pkg::SXU_R_A, sxu_pkg::SXU_R_A, 16'h0000, 8'h36, 1'b1);
    chk(trap_seen, 1'b1);
    stk();
    chk(regs.pc, 16'h5678);
    $display("test trap done");
  endtask

  task automatic t_swi();
    cp(sxu_pkg::SXU_R_B, sxu_pkg::SXU_R_CCR);
    pre = regs;
    s = regs.sp;
    stall = 4'h0;
    run(sxu_pkg::SXU_OP_SWI, sxu_pkg::SXU_R_A, sxu_pkg::SXU_R_A, 16'h0000);
    stk();
    chk(regs.pc, 16'hABCD);
    irq_pending = 1'b1;
    repeat (8) @(negedge ref_clk);
    ld(sxu_pkg::SXU_R_X, 16'h0000);
    chk(takes, 0);
    stall = 4'h2;
    run(sxu_pkg::SXU_OP_RTI, sxu_pkg::SXU_R_A, sxu_pkg::SXU_R_A, 16'h0000);
    chk(regs, pre);
    chk(takes, 1);
    $display("test swi done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    irq_pending = 1'b0;
    stall = 4'h0;
    cmd = '0;
    takes = 0;
    miscompares = 0;
    checks_done = 0;
    trap_seen = 1'b0;
    sxu_mem_model_inst.m[16'hFFF6] = 8'hAB;
    sxu_mem_model_inst.m[16'hFFF7] = 8'hCD;
    sxu_mem_model_inst.m[16'hFFF8] = 8'h56;
    sxu_mem_model_inst.m[16'hFFF9] = 8'h78;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk({regs.condition_flags_register, regs.sp}, 24'hD0_0000);
    t_regs();
    t_cmp();
    t_trap();
    t_swi();
    finish_test();
  end

  // About 160 cycles of work; a generous ceiling cuts hangs
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule // cpu_swi_trap_rti_index_ops_test

// *** sxu_core.sv ***
// Exception entry, return and index register operations
`timescale 1ns/1ps
// How it works
// RL1: Exception entry pushes return address, Y, X, B:A, then flags, predecrementing.
// RL2: After stacking, the program counter loads from the software interrupt vector.
// RL3: Software interrupt is taken regardless of both global mask bits.
// RL4: Exception entry sets the interrupt mask bit.
// RL5: Maskable requests are refused while the interrupt mask bit is set.
// RL6: All page one codes are valid; only 54 page two codes are.
// RL7: Unimplemented page two code raises a trap using the same stacking.
// RL8: Trap handler address comes from the fixed high vector pair.
// RL9: Return pops flags, B:A, X, Y, return address, incrementing the pointer.
// RL10: After return, a pending interrupt is serviced before resuming.
// RL11: Add B to X or Y; load and store SP, X, Y as words.
// RL12: Compare subtracts memory from SP, X or Y, changing only flags.
// RL13: Effective address operation writes the computed address, not memory.
// RL14: Copy any of A, B, flags, D, X, Y, SP to any other.
// RL15: Swap any two of A, B, flags, D, X, Y, SP.
// RL16: Vector fetch reads high byte at lower address, then loads the PC.
module sxu_core (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  // Command port
  input  wire logic               cmd_valid,
  input  sxu_pkg::sxu_cmd_s       cmd,
  output logic                    cmd_ready,
  // Maskable request from interrupt logic
  input  wire logic               irq_pending,
  output logic                    irq_take,
  // Memory bus
  output sxu_pkg::sxu_bus_s       mem,
  input  wire logic [7:0]         mem_rdata,
  input  wire logic               mem_ack,
  // Architectural state
  output sxu_pkg::sxu_regs_s      regs,
  output logic                    trap_taken
);

  typedef enum logic [2:0] {
    SXU_IDLE  = 3'h0,
    SXU_PUSH  = 3'h1,
    SXU_VEC   = 3'h2,
    SXU_POP   = 3'h3,
    SXU_STORE = 3'h4
  } sxu_state_e;

  typedef struct packed {
    sxu_state_e         st;
    sxu_pkg::sxu_regs_s r;
    logic [3:0]         step;
    logic [15:0]        vec;
    logic [7:0]         hold;
    logic [15:0]        sdata;
    logic [15:0]        saddr;
    logic               trap;
    logic               take;
  } sxu_state_s;

  sxu_state_s cur_ff, nxt_ff;
  logic       impl;

  sxu_page2_decode u_dec (
    .opcode      (cmd.opcode),
    .page2       (cmd.page2),
    .implemented (impl)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rd_reg(sxu_pkg::sxu_regs_s r, sxu_pkg::sxu_reg_e s);
    unique case (s)
      sxu_pkg::SXU_R_A:   rd_reg = {8'h00, r.a};
      sxu_pkg::SXU_R_B:   rd_reg = {8'h00, r.b};
      sxu_pkg::SXU_R_CCR: rd_reg = {8'h00, r.condition_flags_register};
      sxu_pkg::SXU_R_D:   rd_reg = {r.a, r.b};
      sxu_pkg::SXU_R_X:   rd_reg = r.x;
      sxu_pkg::SXU_R_Y:   rd_reg = r.y;
      sxu_pkg::SXU_R_SP:  rd_reg = r.sp;
      default:            rd_reg = 16'h0000;
    endcase
  endfunction

  function automatic sxu_pkg::sxu_regs_s wr_reg(sxu_pkg::sxu_regs_s r, sxu_pkg::sxu_reg_e d,
                                                logic [15:0] v);
    wr_reg = r;
    unique case (d)
      sxu_pkg::SXU_R_A:   wr_reg.a = v[7:0];
      sxu_pkg::SXU_R_B:   wr_reg.b = v[7:0];
      sxu_pkg::SXU_R_CCR: wr_reg.condition_flags_register = v[7:0];
      sxu_pkg::SXU_R_D:   {wr_reg.a, wr_reg.b} = v;
      sxu_pkg::SXU_R_X:   wr_reg.x = v;
      sxu_pkg::SXU_R_Y:   wr_reg.y = v;
      sxu_pkg::SXU_R_SP:  wr_reg.sp = v;
      default:            wr_reg = r;
    endcase
  endfunction

  // Byte pushed at each stacking step: 0..1 return, 2..3 Y, 4..5 X, 6..7 B:A, 8 flags
  function automatic logic [7:0] push_byte(sxu_pkg::sxu_regs_s r, logic [3:0] k);
    unique case (k)
      4'h0:    push_byte = r.pc[7:0];
      4'h1:    push_byte = r.pc[15:8];
      4'h2:    push_byte = r.y[7:0];
      4'h3:    push_byte = r.y[15:8];
      4'h4:    push_byte = r.x[7:0];
      4'h5:    push_byte = r.x[15:8];
      4'h6:    push_byte = r.a;
      4'h7:    push_byte = r.b;
      4'h8:    push_byte = r.condition_flags_register;
      default: push_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [16:0] diff;
  logic [15:0] sub_a;
  logic [15:0] tmp16;

  always_comb begin
    nxt_ff     = cur_ff;
    nxt_ff.take = 1'b0;
    sub_a      = rd_reg(cur_ff.r, cmd.src);
    diff       = {1'b0, sub_a} - {1'b0, cmd.operand};
    tmp16      = 16'h0000;
    mem        = '0;
    unique case (cur_ff.st)
      SXU_IDLE: begin
        nxt_ff.trap = 1'b0;
        if (irq_pending && !cur_ff.r.condition_flags_register[sxu_pkg::IMASK_BIT]) begin // RL5 RL10
          nxt_ff.take = 1'b1;
        end else if (cmd_valid) begin
          unique case (cmd.op)
            sxu_pkg::SXU_OP_SWI: begin // RL3
              nxt_ff.st   = SXU_PUSH;
              nxt_ff.step = 4'h0;
              nxt_ff.vec  = sxu_pkg::SWI_VEC_ADDR; // RL2
            end
            sxu_pkg::SXU_OP_DECODE: begin
              if (!impl) begin // RL7
                nxt_ff.st   = SXU_PUSH;
                nxt_ff.step = 4'h0;
                nxt_ff.trap = 1'b1;
                nxt_ff.vec  = sxu_pkg::TRAP_VEC_ADDR; // RL8
              end
            end
            sxu_pkg::SXU_OP_RTI: begin
              nxt_ff.st   = SXU_POP;
              nxt_ff.step = 4'h8;
            end
            sxu_pkg::SXU_OP_ABX: nxt_ff.r.x = cur_ff.r.x + {8'h00, cur_ff.r.b}; // RL11
            sxu_pkg::SXU_OP_ABY: nxt_ff.r.y = cur_ff.r.y + {8'h00, cur_ff.r.b}; // RL11
            sxu_pkg::SXU_OP_CMP: begin // RL12
              nxt_ff.r.condition_flags_register[sxu_pkg::N_BIT] = diff[15];
              nxt_ff.r.condition_flags_register[sxu_pkg::Z_BIT] = (diff[15:0] == 16'h0000);
              nxt_ff.r.condition_flags_register[sxu_pkg::V_BIT] = (sub_a[15] ^ cmd.operand[15]) & (sub_a[15] ^ diff[15]);
              nxt_ff.r.condition_flags_register[sxu_pkg::C_BIT] = diff[16];
            end
            sxu_pkg::SXU_OP_LOAD, sxu_pkg::SXU_OP_LEA: // RL11 RL13
              nxt_ff.r = wr_reg(cur_ff.r, cmd.dst, cmd.operand);
            sxu_pkg::SXU_OP_STORE: begin // RL11
              nxt_ff.st    = SXU_STORE;
              nxt_ff.step  = 4'h0;
              nxt_ff.sdata = sub_a;
              nxt_ff.saddr = cmd.operand;
            end
            sxu_pkg::SXU_OP_COPY: // RL14
              nxt_ff.r = wr_reg(cur_ff.r, cmd.dst, rd_reg(cur_ff.r, cmd.src));
            sxu_pkg::SXU_OP_SWAP: begin // RL15
              nxt_ff.r = wr_reg(cur_ff.r, cmd.dst, rd_reg(cur_ff.r, cmd.src));
              nxt_ff.r = wr_reg(nxt_ff.r, cmd.src, rd_reg(cur_ff.r, cmd.dst));
            end
            default: nxt_ff.st = SXU_IDLE;
          endcase
        end
      end
      SXU_PUSH: begin // RL1
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.addr  = cur_ff.r.sp - 16'h0001;
        mem.wdata = push_byte(cur_ff.r, cur_ff.step);
        if (mem_ack) begin
          nxt_ff.r.sp = cur_ff.r.sp - 16'h0001;
          nxt_ff.step = cur_ff.step + 4'h1;
          if (cur_ff.step == 4'h8) begin
            nxt_ff.st = SXU_VEC;
            nxt_ff.step = 4'h0;
            nxt_ff.r.condition_flags_register[sxu_pkg::IMASK_BIT] = 1'b1; // RL4
          end
        end
      end
      SXU_VEC: begin // RL16
        mem.req  = 1'b1;
        mem.addr = cur_ff.vec + {15'h0000, cur_ff.step[0]};
        if (mem_ack) begin
          if (!cur_ff.step[0]) begin
            nxt_ff.hold = mem_rdata;
            nxt_ff.step = 4'h1;
          end else begin
            nxt_ff.r.pc = {cur_ff.hold, mem_rdata}; // RL2 RL8
            nxt_ff.st   = SXU_IDLE;
          end
        end
      end
      SXU_POP: begin // RL9
        mem.req  = 1'b1;
        mem.addr = cur_ff.r.sp;
        if (mem_ack) begin
          nxt_ff.r.sp = cur_ff.r.sp + 16'h0001;
          unique case (cur_ff.step)
            4'h8: nxt_ff.r.condition_flags_register   = mem_rdata;
            4'h7: nxt_ff.r.b     = mem_rdata;
            4'h6: nxt_ff.r.a     = mem_rdata;
            4'h5: nxt_ff.r.x[15:8] = mem_rdata;
            4'h4: nxt_ff.r.x[7:0]  = mem_rdata;
            4'h3: nxt_ff.r.y[15:8] = mem_rdata;
            4'h2: nxt_ff.r.y[7:0]  = mem_rdata;
            4'h1: nxt_ff.r.pc[15:8] = mem_rdata;
            default: nxt_ff.r.pc[7:0] = mem_rdata;
          endcase
          nxt_ff.step = cur_ff.step - 4'h1;
          if (cur_ff.step == 4'h0) nxt_ff.st = SXU_IDLE;
        end
      end
      SXU_STORE: begin // RL11
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.addr  = cur_ff.saddr + {15'h0000, cur_ff.step[0]};
        mem.wdata = cur_ff.step[0] ? cur_ff.sdata[7:0] : cur_ff.sdata[15:8];
        if (mem_ack) begin
          nxt_ff.step = 4'h1;
          if (cur_ff.step[0]) nxt_ff.st = SXU_IDLE;
        end
      end
      default: nxt_ff.st = SXU_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff       <= '0;
      cur_ff.st    <= SXU_IDLE;
      cur_ff.r.sp  <= sxu_pkg::SP_RESET;
      cur_ff.r.condition_flags_register <= sxu_pkg::CCR_RESET;
    end else if (clk_en) begin
      cur_ff <= nxt_ff;
    end
  end

  assign cmd_ready  = (cur_ff.st == SXU_IDLE) && !(irq_pending && !cur_ff.r.condition_flags_register[sxu_pkg::IMASK_BIT]);
  assign irq_take   = cur_ff.take;
  assign regs       = cur_ff.r;
  assign trap_taken = cur_ff.trap;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_entry_done;
    (cur_ff.st == SXU_PUSH) && mem_ack && clk_en && (cur_ff.step == 4'h8);
  endsequence

  chk_mask_on_entry: assert property (s_entry_done |=> regs.condition_flags_register[sxu_pkg::IMASK_BIT]) // RL4
    else $error("mask bit not set after stacking");
  chk_irq_masked: assert property (irq_take |-> !$past(regs.condition_flags_register[sxu_pkg::IMASK_BIT])) // RL5
    else $error("masked request taken");
  chk_push_order: assert property (cur_ff.st == SXU_PUSH && cur_ff.step == 4'h8 |-> mem.wdata == regs.condition_flags_register) // RL1
    else $error("flags not last pushed");
  chk_push_pre_dec: assert property (cur_ff.st == SXU_PUSH |-> mem.addr == regs.sp - 16'h0001) // RL1
    else $error("push address not predecremented");
  chk_vec_high_first: assert property (cur_ff.st == SXU_VEC && cur_ff.step == 4'h0 |-> mem.addr == cur_ff.vec) // RL16
    else $error("vector high byte not at lower address");
  chk_trap_vector: assert property (cur_ff.trap && cur_ff.st == SXU_VEC |-> cur_ff.vec == sxu_pkg::TRAP_VEC_ADDR) // RL8
    else $error("trap uses wrong vector");
  chk_cmp_keeps: assert property (cmd_ready && cmd_valid && clk_en && cmd.op == sxu_pkg::SXU_OP_CMP
                                  |=> regs.x == $past(regs.x) && regs.y == $past(regs.y)
                                      && regs.sp == $past(regs.sp)) // RL12
    else $error("compare changed a register");
  chk_pop_inc: assert property (cur_ff.st == SXU_POP && mem_ack && clk_en |=> regs.sp == $past(regs.sp) + 16'h0001) // RL9
    else $error("pop did not increment");
  chk_abx_sum: assert property (cmd_ready && cmd_valid && clk_en && cmd.op == sxu_pkg::SXU_OP_ABX
                                |=> regs.x == $past(regs.x) + {8'h00, $past(regs.b)}) // RL11
    else $error("add to index wrong");

endmodule // sxu_core

// *** sxu_mem_model.sv ***
// Byte memory partner holding stack and vectors
`timescale 1ns/1ps
module sxu_mem_model (
  // Clock
  input  wire logic         ref_clk,
  // Bus from the unit
  input  sxu_pkg::sxu_bus_s mem,
  input  wire logic [3:0]   stall,
  output logic [7:0]        mem_rdata,
  output logic              mem_ack
);
  logic [7:0] m [0:65535];
  logic [3:0] cnt_ff;
  logic [7:0] last_ff;
  // Stall stretches every byte to test slow answers
  assign mem_ack = mem.req && (cnt_ff >= stall);
  // Idle bus shows inverted last byte, never a stale copy
  assign mem_rdata = mem_ack ? m[mem.addr] : ~last_ff;
  initial begin
    cnt_ff = 4'h0;
    last_ff = 8'h00;
  end
  always @(posedge ref_clk) begin
    cnt_ff <= (mem_ack || !mem.req) ? 4'h0 : cnt_ff + 4'h1;
    if (mem_ack) begin
      last_ff <= mem_rdata;
      if (mem.we) m[mem.addr] <= mem.wdata;
    end
  end
endmodule // sxu_mem_model

// *** sxu_page2_decode.sv ***
// Second opcode page validity lookup
`timescale 1ns/1ps
module sxu_page2_decode (
  // Opcode in
  input  wire logic [7:0] opcode,
  input  wire logic       page2,
  // Result
  output logic            implemented
);
  // Only a subset of page two is populated; every page one code is valid
  logic [255:0] used_map;
  always_comb begin
    used_map = '0;
    for (int i = 8'h00; i <= 8'h0F; i++) used_map[i] = 1'b1;
    for (int i = 8'h10; i <= 8'h1F; i++) used_map[i] = 1'b1;
    for (int i = 8'h20; i <= 8'h2F; i++) used_map[i] = 1'b1;
    for (int i = 8'h30; i <= 8'h35; i++) used_map[i] = 1'b1;
    implemented = page2 ? used_map[opcode] : 1'b1; // RL6
  end
endmodule // sxu_page2_decode

// *** sxu_pkg.sv ***
// Package: shared types and constants for the exception and index unit
package sxu_pkg;

  localparam logic [15:0] TRAP_VEC_ADDR = 16'hFFF8;
  localparam logic [15:0] SWI_VEC_ADDR  = 16'hFFF6;
  localparam logic [15:0] SP_RESET      = 16'h0000;
  localparam logic [7:0]  CCR_RESET     = 8'hD0;
  localparam int          IMASK_BIT     = 4;
  localparam int          XMASK_BIT     = 6;
  localparam int          N_BIT         = 3;
  localparam int          Z_BIT         = 2;
  localparam int          V_BIT         = 1;
  localparam int          C_BIT         = 0;
  localparam logic [7:0]  PAGE2_PREFIX  = 8'h18;
  localparam int          PAGE2_USED    = 54;

  // Register selector used by copy and swap
  typedef enum logic [2:0] {
    SXU_R_A   = 3'h0,
    SXU_R_B   = 3'h1,
    SXU_R_CCR = 3'h2,
    SXU_R_D   = 3'h4,
    SXU_R_X   = 3'h5,
    SXU_R_Y   = 3'h6,
    SXU_R_SP  = 3'h7
  } sxu_reg_e;

  // Operations accepted on the command port
  typedef enum logic [3:0] {
    SXU_OP_SWI    = 4'h0,
    SXU_OP_RTI    = 4'h1,
    SXU_OP_ABX    = 4'h2,
    SXU_OP_ABY    = 4'h3,
    SXU_OP_CMP    = 4'h4,
    SXU_OP_LOAD   = 4'h5,
    SXU_OP_STORE  = 4'h6,
    SXU_OP_LEA    = 4'h7,
    SXU_OP_COPY   = 4'h8,
    SXU_OP_SWAP   = 4'h9,
    SXU_OP_DECODE = 4'hA
  } sxu_op_e;

  typedef struct packed {
    sxu_op_e     op;
    sxu_reg_e    src;
    sxu_reg_e    dst;
    logic [15:0] operand;
    logic [7:0]  opcode;
    logic        page2;
  } sxu_cmd_s;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  condition_flags_register;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
  } sxu_regs_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sxu_bus_s;

endpackage
